// >>> swr_defs.svh
// Purpose: Timing constants for the supervisor watchdog reset block.
// Assumes: Core clock of 100 MHz; times kept in their printed units.
// Notes:   Cycle counts are derived here, least times rounded up.
`ifndef SWR_DEFS_SVH
`define SWR_DEFS_SVH

// Core clock rate in hertz
`define SWR_CLK_HZ 64'd100000000

// Reset stretch after supply recovers, or from the first drive cycle for the other causes, in ms
`define SWR_RESET_HOLD_MS 64'd500
// Watchdog timeout, typical, in ms
`define SWR_WD_TIMEOUT_MS 64'd700
// Allowed window for the watchdog timeout, in ms
`define SWR_WD_MIN_MS 64'd500
`define SWR_WD_MAX_MS 64'd900
// Least strobe width the processor gives, in ns
`define SWR_STROBE_WIDTH_NS 64'd500
// Longest delay from low supply to pin low, in ns
`define SWR_DETECT_DELAY_NS 64'd100
// Settling time demanded of an external pull-low, in ms
`define SWR_DEBOUNCE_MS 64'd10

// Least time in ms to cycles, rounded up
`define SWR_MS_TO_CYC_UP(ms) (((ms) * `SWR_CLK_HZ + 64'd999) / 64'd1000)
// Least time in ns to cycles, rounded up
`define SWR_NS_TO_CYC_UP(ns) (((ns) * `SWR_CLK_HZ + 64'd999999999) / 64'd1000000000)
// Longest time in ns to cycles, rounded down
`define SWR_NS_TO_CYC_DN(ns) (((ns) * `SWR_CLK_HZ) / 64'd1000000000)

// Cycles from supply detect to pin low in this design
`define SWR_DETECT_LATENCY 64'd1

`endif

// >>> swr_pkg.sv
// Purpose: Types shared by the supervisor watchdog reset block.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes:   Constants live in swr_defs.svh.
package swr_pkg;

    // Supervisor states
    typedef enum logic [1:0] {
        SWR_ST_RUN  = 2'b00,
        SWR_ST_HOLD = 2'b01
    } swr_state_t;

    // Cause of the reset now (or last) driven
    typedef enum logic [1:0] {
        SWR_CAUSE_NONE     = 2'b00,
        SWR_CAUSE_POWER    = 2'b01,
        SWR_CAUSE_WATCHDOG = 2'b10,
        SWR_CAUSE_OVERRIDE = 2'b11
    } swr_cause_t;

    // Sensed level of the shared pin, from the analog front end
    typedef struct packed {
        logic at_reset_low;  // Pin below the logic low level
        logic at_strobe_low; // Pin at or below strobe_low_level
    } swr_pin_sense_t;

    // Open-drain drive of the shared pin
    typedef struct packed {
        logic drive_out;  // Always low
        logic drive_oe_n; // Low while pulling the pin down
    } swr_pin_drive_t;

    // Status for observation
    typedef struct packed {
        logic in_reset;    // Pin is being pulled low by us
        swr_cause_t cause; // What started the present or last reset, or a supply dip during it
    } swr_status_t;

endpackage

// >>> swr_qualify.sv
// Purpose: Level qualifier: flags a level that has stood for CYCLES cycles.
// Assumes: Level and enable synchronous to clk.
// Notes:   Count restarts whenever the level drops or enable is low.
`timescale 1ns/1ps
module swr_qualify #(
    parameter int unsigned CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic level,
    output logic held
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] CMAX = CW'(CYCLES);

    // A zero count would qualify noise at once
    if (CYCLES < 1) begin : g_bad_cycles
        $error("swr_qualify: CYCLES must be at least 1");
    end

    logic [CW-1:0] count; // Cycles the level has stood so far

    // Count up while the level stands, saturate at the target
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!enable || !level) begin
            // Any gap starts the count over
            count <= '0;
        end else if (count != CMAX) begin
            count <= count + CW'(1);
        end
    end

    // Stays high while the level keeps standing
    assign held = (count == CMAX);
endmodule

// >>> swr_supervisor.sv
// Purpose: Supervisor logic behind a shared open-drain reset/strobe pin.
// Assumes: Comparator and pin sense levels are synchronous to core_clk.
// Notes:   Analog thresholds and the divider network sit outside.
// What this block does
// - Low supply pulls pin low within 100 ns
// - Hold pin low 500 ms after supply recovers
// - Open-drain pull-down only, on every reset cause
// - Strobe-level pin restarts watchdog when not resetting
// - Missed strobe gives reset of 500 ms
// - Repeat reset pulses each period until strobed
// - Watchdog timeout 700 ms, inside 500 to 900
// - Debounce external pull-low before treating it
// - Override yields total reset of 500 ms
`timescale 1ns/1ps
`include "swr_defs.svh"
module swr_supervisor
    import swr_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = int'(`SWR_MS_TO_CYC_UP(`SWR_RESET_HOLD_MS)),
    parameter int unsigned WD_CYCLES = int'(`SWR_MS_TO_CYC_UP(`SWR_WD_TIMEOUT_MS)),
    parameter int unsigned DEBOUNCE_CYCLES = int'(`SWR_MS_TO_CYC_UP(`SWR_DEBOUNCE_MS))
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic supply_low,
    input wire swr_pin_sense_t pin_sense,
    output swr_pin_drive_t reset_strobe_pin,
    output swr_status_t status
);
    // Strobe qualification time, short enough to need no parameter
    localparam int unsigned STROBE_CYCLES = int'(`SWR_NS_TO_CYC_UP(`SWR_STROBE_WIDTH_NS));
    // Longest allowed latency from low supply to pin low
    localparam int unsigned DETECT_CYCLES = int'(`SWR_NS_TO_CYC_DN(`SWR_DETECT_DELAY_NS));
    localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
    localparam int unsigned WW = $clog2(WD_CYCLES + 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
    localparam logic [WW-1:0] WD_LAST = WW'(WD_CYCLES - 1);

    // Hold or watchdog counts below two cycles, or a zero debounce, leave the state machine no room
    if (HOLD_CYCLES < 2 || WD_CYCLES < 2 || DEBOUNCE_CYCLES < 1) begin : g_bad_counts
        $error("swr_supervisor: timing counts too small");
    end
    // A watchdog shorter than one strobe could never be fed in time
    if (STROBE_CYCLES + 2 > WD_CYCLES) begin : g_bad_strobe
        $error("swr_supervisor: watchdog shorter than a strobe");
    end

    // The registered drive path must meet the detect delay
    if (`SWR_DETECT_LATENCY > 64'(DETECT_CYCLES)) begin : g_bad_detect
        $error("swr_supervisor: drive latency exceeds detect delay");
    end

    logic rst_meta;              // First reset synchroniser stage
    logic rst_sync_n;            // Released reset used by the design
    swr_state_t state;           // Running or holding reset
    swr_state_t next_state;      // State for the next cycle
    swr_cause_t cause;           // Latched reset cause
    swr_cause_t next_cause;      // Cause for the next cycle
    logic [HW-1:0] hold_count;   // Cycles of the current reset stretch
    logic [WW-1:0] wd_count;     // Cycles since the last valid strobe
    logic drive_oe_n;            // Registered pin enable, low drives
    logic strobe_held;           // Strobe level has stood long enough
    logic strobe_held_q;         // Previous strobe_held, for edge
    logic strobe_event;          // One pulse per valid strobe
    logic override_held;         // External pull-low is debounced
    logic sense_enable;          // Pin sense valid: we are not driving
    logic wd_expired;            // Watchdog reached its timeout

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Sense only while released; our own pull-down would read as a press
    assign sense_enable = drive_oe_n;

    // Strobe must stand a full strobe width; shorter dips are noise
    swr_qualify #(
        .CYCLES(STROBE_CYCLES)
    ) u_strobe (
        .clk(core_clk),
        .rst_n(rst_sync_n),
        .enable(sense_enable),
        .level(pin_sense.at_strobe_low),
        .held(strobe_held)
    );

    // External pull-low is filtered for contact bounce
    swr_qualify #(
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_override (
        .clk(core_clk),
        .rst_n(rst_sync_n),
        .enable(sense_enable),
        .level(pin_sense.at_reset_low),
        .held(override_held)
    );

    // Edge of the qualified strobe; a pin stuck at strobe level
    // restarts the watchdog only once, so it cannot mask a hang
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strobe_held_q <= 1'b0;
        end else begin
            strobe_held_q <= strobe_held;
        end
    end
    assign strobe_event = strobe_held && !strobe_held_q;

    assign wd_expired = (wd_count == WD_LAST);

    // Next state and cause
    always_comb begin
        next_state = state;
        next_cause = cause;
        unique case (state)
            SWR_ST_RUN: begin
                // Supply loss wins over the other causes
                if (supply_low) begin
                    next_state = SWR_ST_HOLD;
                    next_cause = SWR_CAUSE_POWER;
                end else if (override_held) begin
                    next_state = SWR_ST_HOLD;
                    next_cause = SWR_CAUSE_OVERRIDE;
                end else if (wd_expired && !strobe_event) begin
                    next_state = SWR_ST_HOLD;
                    next_cause = SWR_CAUSE_WATCHDOG;
                end
            end
            SWR_ST_HOLD: begin
                // A supply dip during the stretch keeps the reset going
                if (supply_low) begin
                    next_cause = SWR_CAUSE_POWER;
                end else if (hold_count == HOLD_LAST) begin
                    next_state = SWR_ST_RUN;
                end
            end
        endcase
    end

    // State register; power-up starts in the reset stretch
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= SWR_ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Cause register, shown on the status port
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cause <= SWR_CAUSE_POWER;
        end else begin
            cause <= next_cause;
        end
    end

    // Reset stretch counter; counts only with the supply good
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_count <= '0;
        end else if (state != SWR_ST_HOLD || supply_low) begin
            // Restart so the full stretch follows recovery
            hold_count <= '0;
        end else if (hold_count != HOLD_LAST) begin
            // Counts from our first drive cycle, so an override
            // pulse totals at least the stretch time
            hold_count <= hold_count + HW'(1);
        end
    end

    // Watchdog counter; it saturates at expiry, so a missed decision
    // cannot wrap round and hide a hung processor
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wd_count <= '0;
        end else if (state == SWR_ST_HOLD) begin
            // Full period after every reset pulse
            wd_count <= '0;
        end else if (strobe_event) begin
            wd_count <= '0;
        end else if (!wd_expired) begin
            // Expiry re-enters the stretch, and the zero above makes
            // the next pulse come one period later if still silent
            wd_count <= wd_count + WW'(1);
        end
    end

    // Pin enable follows next state, one cycle after supply detect
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            // Pulled low through reset and power-up
            drive_oe_n <= 1'b0;
        end else begin
            drive_oe_n <= (next_state != SWR_ST_HOLD);
        end
    end

    // Open drain: the data side is never high, only the enable moves;
    // one assignment keeps a single driver on the packed port
    assign reset_strobe_pin = '{
        drive_out: 1'b0,
        drive_oe_n: drive_oe_n
    };

    // Status view, taken from registers only
    // so the observer never sees a decode glitch
    assign status = '{
        in_reset: !drive_oe_n,
        cause: cause
    };
endmodule

// >>> swr_supervisor_checker.sv
// Purpose: Concurrent checks on the supervisor's pin drive and status.
// Assumes: Sees only the top module's ports; raw rst_n gates every check.
// Notes:   Timing figures come from the same parameters as the design.
`timescale 1ns/1ps
`include "swr_defs.svh"
module swr_supervisor_checker
    import swr_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = 40,
    parameter int unsigned WD_CYCLES = 200,
    parameter int unsigned DEBOUNCE_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic supply_low,
    input wire swr_pin_sense_t pin_sense,
    input wire swr_pin_drive_t reset_strobe_pin,
    input wire swr_status_t status
);
    // Least strobe width in cycles, as the design qualifies it
    localparam int unsigned STROBE_CYCLES = int'(`SWR_NS_TO_CYC_UP(`SWR_STROBE_WIDTH_NS));
    logic oe_n; // Released drive, high when the pin is let go
    logic strobe_ok; // Strobe level has stood a full strobe width
    int unsigned str_cnt; // Released cycles the strobe level has stood
    int unsigned low_cnt; // Cycles the pin has been pulled low
    int unsigned good_cnt; // Cycles since the supply was last low
    int unsigned hi_cnt; // Cycles the pin has been released
    int unsigned quiet_cnt; // Released cycles since the last full-width strobe
    int unsigned ov_cnt; // Released cycles with an external pull-low
    assign oe_n = reset_strobe_pin.drive_oe_n;
    assign strobe_ok = pin_sense.at_strobe_low && (str_cnt + 1 >= STROBE_CYCLES);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Run-length counters; quiet_cnt clears once a strobe is long enough,
    // short dips do not feed it, and a long strobe clears it late, so it never overstates
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 0;
            good_cnt <= 0;
            hi_cnt <= 0;
            quiet_cnt <= 0;
            ov_cnt <= 0;
            str_cnt <= 0;
        end else begin
            low_cnt <= oe_n ? 0 : low_cnt + 1;
            good_cnt <= supply_low ? 0 : good_cnt + 1;
            hi_cnt <= oe_n ? hi_cnt + 1 : 0;
            quiet_cnt <= (!oe_n || strobe_ok) ? 0 : quiet_cnt + 1;
            str_cnt <= (oe_n && pin_sense.at_strobe_low) ? str_cnt + 1 : 0;
            ov_cnt <= (oe_n && pin_sense.at_reset_low) ? ov_cnt + 1 : 0;
        end
    end
    property p_supply; supply_low |=> !oe_n; endproperty
    property p_od; reset_strobe_pin.drive_out == 1'b0 && status.in_reset == !oe_n; endproperty
    property p_hold; $rose(oe_n) |-> low_cnt >= HOLD_CYCLES; endproperty
    property p_good; $rose(oe_n) |-> good_cnt >= HOLD_CYCLES; endproperty
    property p_wd_late; quiet_cnt >= WD_CYCLES + 2 |-> !oe_n; endproperty
    property p_wd_early;
        $fell(oe_n) && status.cause == SWR_CAUSE_WATCHDOG |-> hi_cnt >= WD_CYCLES - 1;
    endproperty
    property p_ov_early;
        $fell(oe_n) && status.cause == SWR_CAUSE_OVERRIDE |-> ov_cnt >= DEBOUNCE_CYCLES;
    endproperty
    property p_ov_late; ov_cnt >= DEBOUNCE_CYCLES + 2 |-> !oe_n; endproperty
    a_supply: assert property (p_supply)
        else $error("low supply did not pull the pin");
    a_od: assert property (p_od)
        else $error("pin drive is not open drain");
    a_hold: assert property (p_hold)
        else $error("reset pulse too short");
    a_good: assert property (p_good)
        else $error("released too soon after supply recovered");
    a_wd_late: assert property (p_wd_late)
        else $error("watchdog did not expire");
    a_wd_early: assert property (p_wd_early)
        else $error("watchdog expired early");
    a_ov_early: assert property (p_ov_early)
        else $error("override taken before debounce");
    a_ov_late: assert property (p_ov_late)
        else $error("override not taken");
    c_wd: cover property ($fell(oe_n) && status.cause == SWR_CAUSE_WATCHDOG);
    c_ov: cover property ($fell(oe_n) && status.cause == SWR_CAUSE_OVERRIDE);
    c_sup: cover property ($rose(supply_low));
endmodule

// >>> swr_host_model.sv
// Purpose: Host processor and push-button on the shared reset/strobe pin.
// Assumes: Divider makes a strobe reach only the strobe-low level.
// Notes:   Changes at the falling edge; a hard low sets both sense bits.
`timescale 1ns/1ps
module swr_host_model
    import swr_pkg::*;
(
    input wire logic core_clk,
    input wire logic strobe_on,
    input wire logic [7:0] strobe_len,
    input wire logic button,
    input wire swr_pin_drive_t reset_strobe_pin,
    output swr_pin_sense_t pin_sense
);
    logic [7:0] tick = 8'h00; // Position in the strobe period
    logic io_low = 1'b0; // Host I/O line pulling the divider low
    logic hard_low; // Pin forced fully low by someone
    // Period of 120 cycles keeps strobes well inside the watchdog span
    always @(negedge core_clk) begin
        tick <= (!strobe_on || tick == 8'h77) ? 8'h00 : tick + 8'h01;
        io_low <= strobe_on && tick < strobe_len;
    end
    // Button or our own drive takes the wire to ground
    assign hard_low = !reset_strobe_pin.drive_oe_n || button;
    assign pin_sense = '{at_reset_low: hard_low, at_strobe_low: hard_low || io_low};
endmodule

// >>> swr_supervisor_test.sv
// Purpose: Self-checking bench for the supervisor watchdog reset block.
// Assumes: Shortened hold, watchdog and debounce counts.
// Notes:   Inputs change on the falling edge; outputs sampled there too.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module swr_supervisor_test
    import swr_pkg::*;
;
    localparam int HOLD = 40;
    localparam int WD = 200;
    localparam int DEB = 8;
    logic core_clk = 0, rst_n = 0, supply_low = 0, strobe_on = 1, button = 0;
    logic [7:0] strobe_len = 8'h3C; // 60 cycles, above the 50 needed
    swr_pin_sense_t pin_sense;
    swr_pin_drive_t reset_strobe_pin;
    swr_status_t status;
    int n_errors = 0;
    int n_tests = 0;
    swr_supervisor #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD), .DEBOUNCE_CYCLES(DEB)) dut_u (
        .core_clk, .rst_n, .supply_low, .pin_sense, .reset_strobe_pin, .status);
    swr_host_model host_u (
        .core_clk, .strobe_on, .strobe_len, .button, .reset_strobe_pin, .pin_sense);
    initial forever #5 core_clk = ~core_clk;
    task automatic cyc(int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Bounded wait for the pin drive to reach a level
    task automatic wait_oe(logic v, int lim, output int n);
        n = 0;
        while (reset_strobe_pin.drive_oe_n !== v && n < lim) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic t_power;
        int n;
        cyc(3);
        rst_n = 1;
        `CHK("pup_cause", SWR_CAUSE_POWER, status.cause)
        wait_oe(1'b1, 3 * HOLD, n);
        `CHK("pup_len", 1'b1, n >= HOLD && n <= HOLD + 4)
    endtask
    task automatic t_supply;
        int n;
        supply_low = 1;
        cyc(1);
        `CHK("sup_pull", 1'b0, reset_strobe_pin.drive_oe_n)
        `CHK("sup_cause", SWR_CAUSE_POWER, status.cause)
        cyc(20);
        supply_low = 0;
        wait_oe(1'b1, 3 * HOLD, n);
        `CHK("sup_hold", 1'b1, n >= HOLD && n <= HOLD + 3)
    endtask
    task automatic t_strobe;
        int lows = 0;
        repeat (3 * WD) begin
            cyc(1);
            lows += !reset_strobe_pin.drive_oe_n;
        end
        `CHK("strobed_no_reset", 0, lows)
    endtask
    // Strobes of 30 cycles are too short, so pulses repeat each period
    task automatic t_watchdog;
        int n;
        strobe_len = 8'h1E;
        wait_oe(1'b0, 3 * WD, n);
        `CHK("wd_cause", SWR_CAUSE_WATCHDOG, status.cause)
        wait_oe(1'b1, 3 * HOLD, n);
        `CHK("wd_pulse", 1'b1, n >= HOLD - 1 && n <= HOLD + 3)
        wait_oe(1'b0, 3 * WD, n);
        `CHK("wd_period", 1'b1, n >= WD - 2 && n <= WD + 2)
        strobe_len = 8'h3C;
        wait_oe(1'b1, 3 * HOLD, n);
        `CHK("wd_recover", 1'b1, n < 3 * HOLD)
    endtask
    task automatic t_button;
        int n;
        button = 1;
        cyc(DEB - 3);
        button = 0;
        cyc(DEB + 4);
        `CHK("bounce_ignored", 1'b1, reset_strobe_pin.drive_oe_n)
        button = 1;
        wait_oe(1'b0, 3 * DEB, n);
        button = 0;
        `CHK("ov_debounce", 1'b1, n >= DEB && n <= DEB + 2)
        `CHK("ov_cause", SWR_CAUSE_OVERRIDE, status.cause)
        wait_oe(1'b1, 3 * HOLD, n);
        `CHK("ov_pulse", 1'b1, n >= HOLD - 1 && n <= HOLD + 3)
    endtask
    task automatic results;
        $display("n_tests=%0d n_errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        t_power();
        t_supply();
        t_strobe();
        t_watchdog();
        t_button();
        results();
    end
    // Whole run needs under 2000 cycles; cut a hang well past that
    initial begin
        #50000;
        n_errors++;
        results();
    end
endmodule
bind swr_supervisor swr_supervisor_checker #(.HOLD_CYCLES(HOLD_CYCLES),
    .WD_CYCLES(WD_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk_u (
    .core_clk, .rst_n, .supply_low, .pin_sense, .reset_strobe_pin, .status);
